// *** common/cbasc_pkg.sv ***
// Constants, types and register map of the character-buffered serial controller.
// Assumes a single 20 MHz clock and a plain strobe-based register port.
// Overview of operation
// - Bit timing from crystal via 12-bit divider
// - Divided clock runs sixteen times bit rate
// - Divider holds divisor minus one
// - Transmitter and receiver share one divider
// - Start, 5-8 data, parity option, 1-2 stops
// - Two selects pick length; one picks stops
// - Parity enable; sense picks odd or even
// - Only low data byte used on host
// - DMA serves transmit or receive, never both
// - Holding register feeds shifter, bit 0 first
// - Start bit space, stop bits mark
// - Full character to buffer sets input ready
// - Host read clears input ready
// - One-character buffers, independent paths
// - Control: direction, DMA, initialize, option line
// - Sense: buffers, errors, option status input
// - Three interrupts: input, output, error
// - Overrun when buffer reloaded before read
// - Framing error when first stop is zero
// - Break received, never transmitted
// - Default format per interface variant
// - Divider reference is halved oscillator
// - Interrupt outputs are pulses
// - Function codes 0 and 1 connect DMA transmit
package cbasc_pkg;
  // Clock rates in hertz
  localparam logic [24:0] CLK_HZ = 25'h131_2D00;   // 20 MHz system clock
  localparam logic [24:0] REF_HZ = 25'h023_2800;   // 2.304 MHz halved oscillator
  // Register offsets
  localparam logic [3:0] ADDR_DATA = 4'h0;
  localparam logic [3:0] ADDR_STAT = 4'h4;
  localparam logic [3:0] ADDR_FMT = 4'h8;
  localparam logic [3:0] ADDR_CMD = 4'hC;
  // Interface variant: relay defaults to 110 baud and two stop bits
  localparam logic RELAY_VARIANT = 1'h0;
  localparam logic [11:0] DIV_1200 = 12'h077;      // 120 - 1
  localparam logic [11:0] DIV_110 = 12'h51C;       // 1309 - 1
  // Tick positions inside a sixteen-tick bit
  localparam logic [3:0] TICK_HALF = 4'h7;
  localparam logic [3:0] TICK_LAST = 4'hF;
  localparam logic [3:0] DATA_MAX = 4'h8;
  // Character format, one field per select line
  typedef struct packed {
    logic [11:0] divisor_m1;        // Divisor minus one
    logic char_len_select_a;        // Length select, first line
    logic char_len_select_b;        // Length select, second line
    logic stop_count_select;        // High: one stop bit
    logic parity_on_select;         // High: parity present
    logic even_parity_select;       // High: odd parity, low: even
  } cbasc_fmt_t;
  localparam cbasc_fmt_t FMT_RESET = '{
    divisor_m1: RELAY_VARIANT ? DIV_110 : DIV_1200,
    char_len_select_a: 1'h0, char_len_select_b: 1'h0,
    stop_count_select: ~RELAY_VARIANT, parity_on_select: 1'h0,
    even_parity_select: 1'h0};
  // Execute function codes written to the command register
  typedef enum logic [2:0] {
    EXC_DMA_TX0 = 3'h0, EXC_DMA_TX1 = 3'h1, EXC_DMA_RX = 3'h2, EXC_DMA_OFF = 3'h3,
    EXC_INIT = 3'h4, EXC_OPT_SET = 3'h5, EXC_OPT_CLR = 3'h6, EXC_NOP = 3'h7
  } cbasc_exc_t;
  // Serial frame states, shared by both paths
  typedef enum logic [2:0] {
    FR_IDLE = 3'h0, FR_START = 3'h1, FR_DATA = 3'h2, FR_PAR = 3'h3, FR_STOP = 3'h4
  } cbasc_frame_t;
  // Sense word layout, low byte of the status register
  typedef struct packed {
    logic dma_rx_side;              // DMA attached to receive side
    logic dma_connected;            // DMA attached at all
    logic option_status_in;         // External status line level
    logic parity_flag;              // Last character parity bad
    logic framing_flag;             // Last character first stop low
    logic overrun_flag;             // Character lost before read
    logic tx_empty;                 // Holding register free
    logic rx_ready;                 // Received character waiting
  } cbasc_stat_t;
endpackage : cbasc_pkg

// *** hw/cbasc_top.sv ***
// Character-buffered asynchronous serial controller, whole device.
// Assumes a 20 MHz clock, a host strobe port with read data one cycle
// later, and a DMA master that acknowledges once per request.
//
// Design decisions made here: the register offsets and strobed register access.
`timescale 1ns/1ps
module cbasc_top import cbasc_pkg::*; (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Host register port
  input wire logic [3:0] addr,
  input wire logic [15:0] wr_data,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [15:0] rd_data_q,
  // DMA channel
  output logic dma_req_q,
  input wire logic dma_ack,
  input wire logic [15:0] dma_wr_data,
  output logic [15:0] dma_rd_data_q,
  // Serial line and option lines
  input wire logic serial_in,
  output logic serial_out_q,
  input wire logic option_status_in,
  output logic option_control_out_q,
  // Interrupt pulses
  output logic rx_ready_irq_q,
  output logic tx_ready_irq_q,
  output logic err_irq_q
);
  // Data bits for the two length selects
  // First select alone gives six, second alone seven, both five
  function automatic logic [3:0] char_bits(input logic a, input logic b);
    char_bits = DATA_MAX - {2'h0, a, b};
  endfunction : char_bits
  // Parity over the used data bits
  function automatic logic par_of(input logic [7:0] d, input logic odd);
    par_of = ^d ^ odd;
  endfunction : par_of

  // Configuration and control state
  cbasc_fmt_t fmt_q;
  logic dma_conn_q;              // DMA attached
  logic dma_rx_q;                // DMA on receive side
  // Host decode
  wire wr_data_reg = wr_en && addr == ADDR_DATA;
  wire rd_data_reg = rd_en && addr == ADDR_DATA;
  wire wr_fmt = wr_en && addr == ADDR_FMT;
  wire wr_cmd = wr_en && addr == ADDR_CMD;
  cbasc_exc_t execute_function_code;               // Function code of a command write
  assign execute_function_code = cbasc_exc_t'(wr_data[2:0]);
  wire do_init = wr_cmd && execute_function_code == EXC_INIT;
  wire dma_tx_take = dma_ack && dma_conn_q && !dma_rx_q;
  wire dma_rx_take = dma_ack && dma_conn_q && dma_rx_q;
  wire [3:0] nbits = char_bits(fmt_q.char_len_select_a, fmt_q.char_len_select_b);

  // Control register and command port
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      fmt_q <= FMT_RESET;
      dma_conn_q <= 1'h0;
      dma_rx_q <= 1'h0;
      option_control_out_q <= 1'h0;
    end else begin
      // Format word is one bit wider than the bus; top divisor bit stays zero
      if (wr_fmt) fmt_q <= cbasc_fmt_t'({1'h0, wr_data});
      if (wr_cmd) begin
        case (execute_function_code)
          EXC_DMA_TX0, EXC_DMA_TX1: begin
            dma_conn_q <= 1'h1;
            dma_rx_q <= 1'h0;
          end
          EXC_DMA_RX: begin
            dma_conn_q <= 1'h1;
            dma_rx_q <= 1'h1;
          end
          // Initialize detaches DMA too; the option line keeps its level
          EXC_DMA_OFF, EXC_INIT: dma_conn_q <= 1'h0;
          EXC_OPT_SET: option_control_out_q <= 1'h1;
          EXC_OPT_CLR: option_control_out_q <= 1'h0;
          default: ;
        endcase
      end
    end
  end

  // Reference enable: 2.304 MHz average rate from the 20 MHz clock
  // Accumulator keeps the long-run rate exact without a second clock
  logic [24:0] acc_q;
  logic ref_en_q;
  wire [24:0] acc_sum = acc_q + REF_HZ;
  wire acc_wrap = acc_sum >= CLK_HZ;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      acc_q <= 25'h000_0000;
      ref_en_q <= 1'h0;
    end else begin
      acc_q <= acc_wrap ? acc_sum - CLK_HZ : acc_sum;
      ref_en_q <= acc_wrap;
    end
  end

  // Shared 12-bit divider giving the sixteen-times tick
  // Reloading on zero makes a count of N-1 divide by N
  logic [11:0] div_q;
  logic tick_q;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      div_q <= 12'h000;
      tick_q <= 1'h0;
    end else begin
      tick_q <= ref_en_q && div_q == 12'h000;
      if (ref_en_q) div_q <= (div_q == 12'h000) ? fmt_q.divisor_m1 : div_q - 12'h001;
    end
  end

  // Transmit path: holding register then shifter
  logic [7:0] hold_q;
  logic hold_full_q;
  logic [7:0] tsh_q;
  cbasc_frame_t tst_q;
  logic [3:0] tsub_q;
  logic [3:0] tcnt_q;
  logic tpar_q;
  // A frame starts only on a tick while the shifter is idle
  wire tx_load = tick_q && tst_q == FR_IDLE && hold_full_q;
  wire tx_bit_end = tick_q && tst_q != FR_IDLE && tsub_q == TICK_LAST;
  wire host_tx_wr = wr_data_reg || dma_tx_take;
  wire [7:0] tx_word = wr_data_reg ? wr_data[7:0] : dma_wr_data[7:0];

  // Holding register: a new write wins over the shifter taking it
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      hold_q <= 8'h00;
      hold_full_q <= 1'h0;
    end else if (do_init) begin
      hold_full_q <= 1'h0;
    end else if (host_tx_wr) begin
      hold_q <= tx_word;
      hold_full_q <= 1'h1;
    end else if (tx_load) begin
      hold_full_q <= 1'h0;
    end
  end

  // Transmit frame sequencer; no break can be sent since idle is mark
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      tst_q <= FR_IDLE;
      tsh_q <= 8'h00;
      tsub_q <= 4'h0;
      tcnt_q <= 4'h0;
      tpar_q <= 1'h0;
      serial_out_q <= 1'h1;
    end else if (do_init) begin
      tst_q <= FR_IDLE;
      serial_out_q <= 1'h1;
    end else if (tx_load) begin
      tsh_q <= hold_q;
      tpar_q <= par_of(hold_q & (8'hFF >> (DATA_MAX - nbits)), fmt_q.even_parity_select);
      tst_q <= FR_START;
      tsub_q <= 4'h0;
      serial_out_q <= 1'h0;
    end else if (tick_q && tst_q != FR_IDLE) begin
      tsub_q <= tsub_q + 4'h1;
      if (tx_bit_end) begin
        case (tst_q)
          FR_START: begin
            tst_q <= FR_DATA;
            tcnt_q <= 4'h1;
            serial_out_q <= tsh_q[0];
            tsh_q <= tsh_q >> 1;
          end
          FR_DATA: begin
            if (tcnt_q == nbits) begin
              tst_q <= fmt_q.parity_on_select ? FR_PAR : FR_STOP;
              serial_out_q <= fmt_q.parity_on_select ? tpar_q : 1'h1;
              tcnt_q <= 4'h0;
            end else begin
              tcnt_q <= tcnt_q + 4'h1;
              serial_out_q <= tsh_q[0];
              tsh_q <= tsh_q >> 1;
            end
          end
          FR_PAR: begin
            tst_q <= FR_STOP;
            serial_out_q <= 1'h1;
          end
          FR_STOP: begin
            serial_out_q <= 1'h1;
            if (!fmt_q.stop_count_select && tcnt_q == 4'h0) tcnt_q <= 4'h1;
            else tst_q <= FR_IDLE;
          end
          default: tst_q <= FR_IDLE;
        endcase
      end
    end
  end

  // Receive path
  logic [7:0] rsh_q;
  logic [7:0] rbuf_q;
  logic rx_ready_q;
  logic overrun_q;
  logic framing_q;
  logic parerr_q;
  cbasc_frame_t rst_q;
  logic [3:0] rsub_q;
  logic [3:0] rcnt_q;
  logic rpar_q;
  wire rx_mid = tick_q && rsub_q == TICK_LAST;
  wire rx_load = rx_mid && rst_q == FR_STOP;
  wire host_rx_rd = rd_data_reg || dma_rx_take;
  wire [7:0] rx_just = rsh_q >> (DATA_MAX - nbits);
  wire par_bad = fmt_q.parity_on_select && (par_of(rx_just, fmt_q.even_parity_select) != rpar_q);

  // Receive frame sequencer
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rst_q <= FR_IDLE;
      rsh_q <= 8'h00;
      rsub_q <= 4'h0;
      rcnt_q <= 4'h0;
      rpar_q <= 1'h0;
    end else if (do_init) begin
      rst_q <= FR_IDLE;
    end else if (tick_q) begin
      rsub_q <= rsub_q + 4'h1;
      case (rst_q)
        FR_IDLE: begin
          rsub_q <= 4'h0;
          if (!serial_in) rst_q <= FR_START;
        end
        FR_START: begin
          if (rsub_q == TICK_HALF) begin
            rst_q <= serial_in ? FR_IDLE : FR_DATA;
            // Restart the count so every data sample lands mid-bit
            rsub_q <= 4'h0;
            rcnt_q <= 4'h0;
          end
        end
        FR_DATA: begin
          if (rx_mid) begin
            rsh_q <= {serial_in, rsh_q[7:1]};
            rcnt_q <= rcnt_q + 4'h1;
            if (rcnt_q + 4'h1 == nbits) rst_q <= fmt_q.parity_on_select ? FR_PAR : FR_STOP;
          end
        end
        FR_PAR: begin
          if (rx_mid) begin
            rpar_q <= serial_in;
            rst_q <= FR_STOP;
          end
        end
        FR_STOP: if (rx_mid) rst_q <= FR_IDLE;
        default: rst_q <= FR_IDLE;
      endcase
    end
  end

  // Receive buffer and error flags; a new character wins over a read
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rbuf_q <= 8'h00;
      rx_ready_q <= 1'h0;
      overrun_q <= 1'h0;
      framing_q <= 1'h0;
      parerr_q <= 1'h0;
    end else if (do_init) begin
      rx_ready_q <= 1'h0;
      overrun_q <= 1'h0;
      framing_q <= 1'h0;
      parerr_q <= 1'h0;
    end else if (rx_load) begin
      rbuf_q <= rx_just;
      rx_ready_q <= 1'h1;
      // Overrun looks at the ready flag from before this load
      overrun_q <= rx_ready_q && !host_rx_rd;
      framing_q <= !serial_in;
      parerr_q <= par_bad;
    end else if (host_rx_rd) begin
      rx_ready_q <= 1'h0;
    end
  end

  // Sense word, read data, DMA request and interrupt pulses
  cbasc_stat_t stat;
  assign stat = '{dma_rx_side: dma_rx_q, dma_connected: dma_conn_q,
                  option_status_in: option_status_in, parity_flag: parerr_q,
                  framing_flag: framing_q, overrun_flag: overrun_q,
                  tx_empty: !hold_full_q, rx_ready: rx_ready_q};
  wire [7:0] rd_mux = (addr == ADDR_DATA) ? rbuf_q :
                      (addr == ADDR_STAT) ? stat : 8'h00;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rd_data_q <= 16'h0000;
      dma_rd_data_q <= 16'h0000;
      dma_req_q <= 1'h0;
      rx_ready_irq_q <= 1'h0;
      tx_ready_irq_q <= 1'h0;
      err_irq_q <= 1'h0;
    end else begin
      rd_data_q <= rd_en ? {8'h00, rd_mux} : 16'h0000;
      if (dma_rx_take) dma_rd_data_q <= {8'h00, rbuf_q};
      dma_req_q <= dma_conn_q && !dma_ack && (dma_rx_q ? rx_ready_q : !hold_full_q);
      rx_ready_irq_q <= rx_load;
      tx_ready_irq_q <= tx_load && !host_tx_wr;
      err_irq_q <= rx_load && (!serial_in || (rx_ready_q && !host_rx_rd));
    end
  end

  // Checks on the design's own outputs
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  sequence s_rx_done;
    rx_load && !do_init;
  endsequence
  sequence s_host_take;
    host_rx_rd && !rx_load && !do_init;
  endsequence
  AST_RX_READY: assert property (s_rx_done |=> rx_ready_q && rx_ready_irq_q)
    else $error("input ready not set after character");
  AST_READ_CLEAR: assert property (s_host_take |=> !rx_ready_q)
    else $error("input ready not cleared by read");
  AST_OVERRUN: assert property (s_rx_done ##0 (rx_ready_q && !host_rx_rd) |=> overrun_q && err_irq_q)
    else $error("overrun not flagged");
  AST_FRAMING: assert property (s_rx_done ##0 !serial_in |=> framing_q ##0 err_irq_q)
    else $error("framing error not flagged");
  AST_START_SPACE: assert property (tst_q == FR_START |-> !serial_out_q)
    else $error("start bit not space");
  AST_STOP_MARK: assert property (tst_q == FR_STOP || tst_q == FR_IDLE |-> serial_out_q)
    else $error("stop or idle not mark");
  AST_IRQ_PULSE: assert property ($rose(err_irq_q) |=> !err_irq_q)
    else $error("error interrupt held");
  AST_UPPER_ZERO: assert property ($past(rd_en) |-> rd_data_q[15:8] == 8'h00)
    else $error("upper data byte driven");
  AST_DMA_SIDE: assert property (dma_req_q |-> $past(dma_conn_q))
    else $error("DMA request while detached");
  AST_TICK_GAP: assert property (tick_q |=> !tick_q)
    else $error("tick not a pulse");
  // Initialize empties both buffers; short characters carry zero upper bits
  AST_INIT_CLEAR: assert property (do_init |=> !rx_ready_q && !hold_full_q)
    else $error("initialize did not clear buffers");
  AST_RX_JUSTIFY: assert property (s_rx_done |=> (rbuf_q >> $past(nbits)) == 8'h00)
    else $error("unused receive bits not zero");
endmodule : cbasc_top

// *** verification/cbasc_line_model.sv ***
// Far-end serial device: sends whole frames and captures what it hears.
// Assumes a mark-idle line; one bit lasts BITC clocks of the 20 MHz clock.
`timescale 1ns/1ps
module cbasc_line_model #(
  parameter int BITC = 139,          // Clocks per bit, divisor of one
  parameter real BIT_NS = 6944.444   // Bit time used by the sampler
) (
  // Clock
  input wire logic clk,
  // Serial lines
  input wire logic line_in,
  output logic line_out,
  // Last captured frame and count of frames
  output logic [11:0] cap_bits,
  output int cap_count
);
  int k;  // Sample index
  // Idle line stays at mark
  initial begin
    line_out = 1'b1;
    cap_bits = '1;
    cap_count = 0;
  end
  // Sample twelve bit centres after each falling start edge
  always begin
    @(negedge line_in);
    #(BIT_NS / 2.0);
    for (k = 0; k < 12; k++) begin
      cap_bits[k] = line_in;
      #(BIT_NS);
    end
    cap_count++;
  end
  // Send len bits of f, bit 0 first, then one bit of idle mark
  task automatic send(input logic [11:0] f, input int len);
    int i;
    for (i = 0; i < len; i++) begin
      @(posedge clk);
      line_out <= f[i];
      repeat (BITC - 1) @(posedge clk);
    end
    @(posedge clk);
    line_out <= 1'b1;
    repeat (BITC) @(posedge clk);
  endtask : send
endmodule : cbasc_line_model

// *** verification/tb_top.sv ***
// Self-checking bench of the serial controller: registers, line, DMA.
// Assumes cbasc_top and the line model; a single 20 MHz clock.
`timescale 1ns/1ps
module tb_top import cbasc_pkg::*; ;
  logic clk, nrst, wr_en, rd_en, dma_ack, serial_in, serial_out_q, option_status_in;
  logic dma_req_q, option_control_out_q, rx_ready_irq_q, tx_ready_irq_q, err_irq_q;
  logic [3:0] addr;
  logic [15:0] wr_data, dma_wr_data, rd_data_q, dma_rd_data_q;
  logic [11:0] cap_bits;
  int cap_count, errors, cmp_count, cyc;
  int irq_n [3];  // Pulse-cycle counts: input, output, error
  // Formats {len_a, len_b, one stop, parity on, odd}: 5, 6, 7 and 8 bits
  localparam logic [4:0] FMTS [4] = '{5'h1F, 5'h16, 5'h08, 5'h07};

  cbasc_top DUT (.clk, .nrst, .addr, .wr_data, .wr_en, .rd_en, .rd_data_q,
    .dma_req_q, .dma_ack, .dma_wr_data, .dma_rd_data_q, .serial_in, .serial_out_q,
    .option_status_in, .option_control_out_q, .rx_ready_irq_q, .tx_ready_irq_q, .err_irq_q);
  cbasc_line_model u_line (.clk, .line_in(serial_out_q), .line_out(serial_in),
    .cap_bits, .cap_count);

  // Clock of 50 ns period
  initial clk = 1'b0;
  always #25 clk = ~clk;

  // Count interrupt cycles; a held level shows up as extra counts
  always @(posedge clk) begin
    cyc++;
    if (rx_ready_irq_q === 1'b1) irq_n[0]++;
    if (tx_ready_irq_q === 1'b1) irq_n[1]++;
    if (err_irq_q === 1'b1) irq_n[2]++;
    if (cyc == 60000) begin
      errors++;
      complete_run();
    end
  end

  task check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task complete_run;
    $display("checks %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : complete_run

  // One-cycle register write; outputs settle before return
  task wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    addr <= a;
    wr_data <= d;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
    #1;
  endtask : wr

  // Read, then compare the masked data of the following cycle
  task rd_chk(input string what, input logic [3:0] a, input logic [15:0] m, e);
    @(posedge clk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    #1;
    check(what, rd_data_q & m, e);
  endtask : rd_chk

  // One DMA transfer pulse
  task ack(input logic [15:0] d);
    @(posedge clk);
    dma_ack <= 1'b1;
    dma_wr_data <= d;
    @(posedge clk);
    dma_ack <= 1'b0;
    #1;
  endtask : ack

  // Wait for a captured frame, then let the last stop bit finish
  task wait_cap(input int c0);
    int k;
    for (k = 0; k < 3000 && cap_count == c0; k++) @(posedge clk);
    repeat (150) @(posedge clk);
  endtask : wait_cap

  function automatic int nbits(input logic [4:0] fm);
    return fm[4] ? (fm[3] ? 5 : 6) : (fm[3] ? 7 : 8);
  endfunction : nbits

  function automatic int flen(input logic [4:0] fm);
    return nbits(fm) + 1 + int'(fm[1]) + (fm[2] ? 1 : 2);
  endfunction : flen

  // Expected line bits: start space, data LSB first, parity, mark beyond
  function automatic logic [11:0] frame(input logic [7:0] d, input logic [4:0] fm);
    logic [11:0] f;
    int i;
    logic p;
    f = '1;
    f[0] = 1'b0;
    p = fm[0];
    for (i = 0; i < nbits(fm); i++) begin
      f[i + 1] = d[i];
      p ^= d[i];
    end
    if (fm[1]) f[nbits(fm) + 1] = p;
    return f;
  endfunction : frame

  task t_reset;
    check("serial idle", {15'h0, serial_out_q}, 16'h0001);
    rd_chk("status", ADDR_STAT, 16'hFFFF, 16'h0022);
    wr(ADDR_STAT, 16'hFFFF);
    rd_chk("status kept", ADDR_STAT, 16'hFFFF, 16'h0022);
    rd_chk("unmapped", 4'h2, 16'hFFFF, 16'h0000);
    wr(ADDR_CMD, 16'h0005);
    check("option set", {15'h0, option_control_out_q}, 16'h0001);
    wr(ADDR_CMD, 16'h0006);
    check("option clr", {15'h0, option_control_out_q}, 16'h0000);
    @(posedge clk);
    option_status_in <= 1'b0;
    rd_chk("option in", ADDR_STAT, 16'h0020, 16'h0000);
    @(posedge clk);
    option_status_in <= 1'b1;
    $display("reset test done");
  endtask : t_reset

  task t_tx;
    int i, c0, n0;
    for (i = 0; i < 4; i++) begin
      wr(ADDR_FMT, {11'h0, FMTS[i]});
      c0 = cap_count;
      n0 = irq_n[1];
      wr(ADDR_DATA, 16'h5AA7);
      wait_cap(c0);
      check("tx frame", {4'h0, cap_bits}, {4'h0, frame(8'hA7, FMTS[i])});
      check("tx irq", 16'(irq_n[1] - n0), 16'h0001);
      rd_chk("tx empty", ADDR_STAT, 16'h0002, 16'h0002);
    end
    $display("transmit test done");
  endtask : t_tx

  task t_rx;
    int i, n0;
    logic [7:0] ch;
    for (i = 0; i < 4; i++) begin
      ch = 8'h9C + 8'(i);
      wr(ADDR_FMT, {11'h0, FMTS[i]});
      n0 = irq_n[0];
      u_line.send(frame(ch, FMTS[i]), flen(FMTS[i]));
      rd_chk("rx ready", ADDR_STAT, 16'h001F, 16'h0003);
      check("rx irq", 16'(irq_n[0] - n0), 16'h0001);
      rd_chk("rx data", ADDR_DATA, 16'hFFFF, {8'h0, ch & (8'hFF >> (8 - nbits(FMTS[i])))});
      rd_chk("ready clr", ADDR_STAT, 16'h0001, 16'h0000);
    end
    $display("receive test done");
  endtask : t_rx

  task t_err;
    int n0;
    logic [11:0] f;
    f = frame(8'h00, FMTS[3]);
    f[10] = 1'b0;
    n0 = irq_n[2];
    u_line.send(f, 11);
    rd_chk("framing", ADDR_STAT, 16'h001F, 16'h000B);
    check("err irq", 16'(irq_n[2] - n0), 16'h0001);
    rd_chk("break data", ADDR_DATA, 16'hFFFF, 16'h0000);
    n0 = irq_n[2];
    u_line.send(frame(8'h11, FMTS[3]), 11);
    u_line.send(frame(8'h22, FMTS[3]), 11);
    rd_chk("overrun", ADDR_STAT, 16'h0007, 16'h0007);
    check("ovr irq", 16'(irq_n[2] - n0), 16'h0001);
    rd_chk("newest", ADDR_DATA, 16'hFFFF, 16'h0022);
    f = frame(8'h55, FMTS[3]);
    f[9] = ~f[9];
    u_line.send(f, 11);
    rd_chk("parity", ADDR_STAT, 16'h001F, 16'h0013);
    wr(ADDR_CMD, 16'h0004);
    rd_chk("init", ADDR_STAT, 16'h001F, 16'h0002);
    $display("error test done");
  endtask : t_err

  task t_dma;
    int c0;
    wr(ADDR_CMD, 16'h0002);
    rd_chk("dma rx", ADDR_STAT, 16'h00C0, 16'h00C0);
    u_line.send(frame(8'h3C, FMTS[3]), 11);
    check("rx req", {15'h0, dma_req_q}, 16'h0001);
    ack(16'h0000);
    check("dma data", dma_rd_data_q, 16'h003C);
    wr(ADDR_CMD, 16'h0000);
    rd_chk("dma tx0", ADDR_STAT, 16'h00C0, 16'h0040);
    wr(ADDR_CMD, 16'h0001);
    rd_chk("dma tx1", ADDR_STAT, 16'h00C0, 16'h0040);
    check("tx req", {15'h0, dma_req_q}, 16'h0001);
    c0 = cap_count;
    ack(16'hFF81);
    wait_cap(c0);
    check("dma frame", {4'h0, cap_bits}, {4'h0, frame(8'h81, FMTS[3])});
    wr(ADDR_CMD, 16'h0003);
    repeat (2) @(posedge clk);
    check("detached", {15'h0, dma_req_q}, 16'h0000);
    $display("dma test done");
  endtask : t_dma

  // Reset for 20 cycles, then run every scenario
  initial begin
    nrst = 1'b0;
    addr = 4'h0;
    wr_data = 16'h0000;
    wr_en = 1'b0;
    rd_en = 1'b0;
    dma_ack = 1'b0;
    dma_wr_data = 16'h0000;
    option_status_in = 1'b1;
    repeat (20) @(posedge clk);
    nrst <= 1'b1;
    t_reset();
    t_tx();
    t_rx();
    t_err();
    t_dma();
    complete_run();
  end
endmodule : tb_top
